// File: shared/i2cs_pkg.sv
/*
 * package of the two-wire slave with clock-line time-out:
 * register indices, field positions, reset values, timing counts, fsm states.
 * assumes an 8-bit register port with a 4-bit register index.
 */
package i2cs_pkg;

    // ****************************************
    // register index map
    // ****************************************
    localparam logic [3:0] REG_CTRL_ZERO = 4'h0;
    localparam logic [3:0] REG_CTRL_ONE  = 4'h1;
    localparam logic [3:0] REG_OWN_ADDR  = 4'h2;
    localparam logic [3:0] REG_DATA      = 4'h3;
    localparam logic [3:0] REG_TMO_CTRL  = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT  = 4'h5;
    localparam logic [3:0] REG_IRQ_CLR   = 4'h6;
    localparam logic [3:0] REG_IRQ_EN    = 4'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CZ_ENABLE   = 0;
    localparam int C1_MATCH    = 7;
    localparam int C1_BUSY     = 6;
    localparam int C1_TXSEL    = 4;
    localparam int C1_ACKSEND  = 3;
    localparam int C1_MRREQ    = 2;
    localparam int C1_ACKRCV   = 0;
    localparam int TO_ENABLE   = 7;
    localparam int TO_FLAG     = 6;
    localparam int IRQ_MATCH   = 0;
    localparam int IRQ_BYTE    = 1;
    localparam int IRQ_TMO     = 2;
    localparam int IRQ_BITS    = 3;
    localparam int SCL_IDX     = 0;
    localparam int SDA_IDX     = 1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] RST_TMO     = 8'h00;
    localparam logic [2:0] RST_IRQ     = 3'h0;

    // ****************************************
    // timing counts
    // ****************************************
    localparam int         SUB_DIV     = 32;
    localparam logic [4:0] SUB_DIV_MAX = 5'(SUB_DIV - 1);
    localparam logic [3:0] BYTE_BITS   = 4'h8;

    // ****************************************
    // bus states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_HOLD, ST_TX, ST_TXACK, ST_RX, ST_RXACK, ST_WAIT
    } i2cs_state_t;

endpackage

// File: design/i2cs_tmo.sv
/*
 * time-out counter of the two-wire slave, ticking on the sub-clock divided by 32.
 * assumes subclk_i is a slow pin clock and the pulses arm, clr, halt come from clk logic.
 */
`timescale 1ns/100ps
module i2cs_tmo (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // sub-clock pin
    input  wire logic       subclk_i,
    // control
    input  wire logic       arm,
    input  wire logic       clr,
    input  wire logic       halt,
    input  wire logic       enable,
    input  wire logic [5:0] period,
    // result
    output logic            overflow_r
);
    import i2cs_pkg::*;

    // ****************************************
    // sub-clock sampling
    // ****************************************
    logic       m1_r, m2_r, m3_r, sub_r;
    logic       tick;
    logic       run_r;
    logic [4:0] div_r;
    logic [5:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            m1_r <= 1'b0;
            m2_r <= 1'b0;
            m3_r <= 1'b0;
            sub_r <= 1'b0;
        end else begin
            m1_r <= subclk_i;
            m2_r <= m1_r;
            m3_r <= m2_r;
            if (m2_r == m3_r)
                sub_r <= m3_r;
        end
    end

    assign tick = (m2_r == m3_r) && m3_r && !sub_r;

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            run_r <= 1'b0;
            div_r <= 5'h0;
            cnt_r <= 6'h0;
            overflow_r <= 1'b0;
        end else begin
            overflow_r <= 1'b0;
            if (halt || overflow_r) begin
                run_r <= 1'b0;  // RULE11
            end else if (arm) begin
                run_r <= 1'b1;  // RULE9
            end
            if (clr || arm) begin
                div_r <= 5'h0;  // RULE9
                cnt_r <= 6'h0;
            end else if (run_r && enable && tick) begin  // RULE18
                div_r <= div_r + 5'h1;
                if (div_r == SUB_DIV_MAX) begin
                    cnt_r <= cnt_r + 6'h1;
                    if (cnt_r == period) begin
                        overflow_r <= 1'b1;  // RULE10 RULE15
                        run_r <= 1'b0;  // RULE12
                    end
                end
            end
        end
    end

    a_clear_on_fall: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        clr |=> (cnt_r == 6'h0) && (div_r == 5'h0))
        else $error("time-out count not cleared by clock fall");

    a_no_count_off: assert property (@(posedge clk) disable iff (!rstn) // RULE18
        (!enable && !clr && !arm) |=> $stable(cnt_r))
        else $error("time-out counted while disabled");

endmodule // i2cs_tmo

// File: design/i2cs_slave.sv
/*
 * two-wire bus slave: address match, byte transfer with acknowledge,
 * clock stretching until software touches the data buffer, time-out watchdog.
 * assumes an external master on the pins and software on the 8-bit register port.
 */
// Behaviour
// RULE1: acknowledge when calling address matches own
// RULE2: master sends stop when no acknowledge
// RULE3: software sets transmit select from read request
// RULE4: 8-bit bytes, msb first, after address ack
// RULE5: receiver acknowledges low on ninth clock
// RULE6: transmitter stops and releases on no ack
// RULE7: all bytes pass through data buffer
// RULE8: clock held low until buffer access
// RULE9: counter starts on match, cleared each fall
// RULE10: time-out when gap exceeds period
// RULE11: supervision stops on stop condition
// RULE12: overflow stops counter, flags, interrupts
// RULE13: time-out resets logic and control one
// RULE14: time-out flag cleared only by software zero
// RULE15: period is n+1 ticks of sub/32
// RULE16: seven-bit address compare sets match flag
// RULE17: eighth bit captured as read request
// RULE18: count only when enabled, events synchronised
// RULE19: hold clock low after each byte; code skips the hold after a transmitted byte that gets no ack
`timescale 1ns/100ps
module i2cs_slave (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_r,
    // two-wire pins
    input  wire logic       scl_i,
    output logic            scl_o_r,
    output logic            scl_oe_r,
    input  wire logic       sda_i,
    output logic            sda_o_r,
    output logic            sda_oe_r,
    // sub-clock pin
    input  wire logic       subclk_i,
    // interrupt
    output logic            irq_r
);
    import i2cs_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    i2cs_state_t   state_r;
    logic [1:0]    m1_r, m2_r, m3_r, lvl_r;
    logic [1:0]    chg;
    logic          scl_rise, scl_fall, start_det, stop_det;
    logic [7:0]    ctrl_zero_r, own_addr_r, data_r, tmo_ctrl_r;
    logic [7:0]    shift_r, tx_sh_r;
    logic [3:0]    cnt_r;
    logic          txsel_r, acksend_r, match_r, busy_r, mrreq_r, ackrcv_r;
    logic          ev_match, ev_byte, tmo_ovf;
    logic [2:0]    irq_stat_r, irq_en_r, events;
    logic          wr_data, rd_data, release_hold, rx_load, enabled;
    logic [7:0]    rdata_nxt;

    // ****************************************
    // pin synchronisers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    m1_r[gi] <= 1'b1;
                    m2_r[gi] <= 1'b1;
                    m3_r[gi] <= 1'b1;
                    lvl_r[gi] <= 1'b1;
                end else begin
                    m1_r[gi] <= (gi == SCL_IDX) ? scl_i : sda_i;
                    m2_r[gi] <= m1_r[gi];
                    m3_r[gi] <= m2_r[gi];
                    if (m2_r[gi] == m3_r[gi])
                        lvl_r[gi] <= m3_r[gi];
                end
            end
            assign chg[gi] = (m2_r[gi] == m3_r[gi]) && (m3_r[gi] != lvl_r[gi]);
        end
    endgenerate

    assign scl_rise  = chg[SCL_IDX] && m3_r[SCL_IDX];
    assign scl_fall  = chg[SCL_IDX] && !m3_r[SCL_IDX];
    assign start_det = chg[SDA_IDX] && !m3_r[SDA_IDX] && lvl_r[SCL_IDX];
    assign stop_det  = chg[SDA_IDX] && m3_r[SDA_IDX] && lvl_r[SCL_IDX];
    assign enabled   = ctrl_zero_r[CZ_ENABLE];

    // ****************************************
    // register access decode
    // ****************************************
    assign wr_data      = reg_wr && (reg_addr == REG_DATA);
    assign rd_data      = reg_rd && (reg_addr == REG_DATA);
    assign release_hold = (state_r == ST_HOLD) && (txsel_r ? wr_data : rd_data);  // RULE8
    assign rx_load      = (state_r == ST_RX) && scl_fall && (cnt_r == BYTE_BITS);

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_zero_r <= RST_BYTE;
            own_addr_r <= RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL_ZERO)
                ctrl_zero_r <= reg_wdata;
            if (reg_addr == REG_OWN_ADDR)
                own_addr_r <= {reg_wdata[7:1], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_r <= RST_BYTE;
        end else if (rx_load) begin
            data_r <= shift_r;  // RULE7
        end else if (wr_data) begin
            data_r <= reg_wdata;  // RULE7
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || tmo_ovf) begin
            txsel_r <= 1'b0;  // RULE13
            acksend_r <= 1'b0;
        end else if (reg_wr && (reg_addr == REG_CTRL_ONE)) begin
            txsel_r <= reg_wdata[C1_TXSEL];  // RULE3
            acksend_r <= reg_wdata[C1_ACKSEND];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tmo_ctrl_r <= RST_TMO;
        end else begin
            if (reg_wr && (reg_addr == REG_TMO_CTRL)) begin
                tmo_ctrl_r[TO_ENABLE] <= reg_wdata[TO_ENABLE];
                tmo_ctrl_r[TO_FLAG] <= tmo_ctrl_r[TO_FLAG] & reg_wdata[TO_FLAG];  // RULE14
                tmo_ctrl_r[5:0] <= reg_wdata[5:0];
            end
            if (tmo_ovf) begin
                tmo_ctrl_r[TO_ENABLE] <= 1'b0;  // RULE12
                tmo_ctrl_r[TO_FLAG] <= 1'b1;  // RULE12 RULE14
            end
        end
    end

    // ****************************************
    // time-out counter
    // ****************************************
    i2cs_tmo i_i2cs_tmo (
        .clk        (clk),
        .rstn       (rstn),
        .subclk_i   (subclk_i),
        .arm        (ev_match),
        .clr        (scl_fall),
        .halt       (stop_det),
        .enable     (tmo_ctrl_r[TO_ENABLE]),
        .period     (tmo_ctrl_r[5:0]),
        .overflow_r (tmo_ovf)
    );

    // ****************************************
    // bus state machine
    // ****************************************
    assign ev_match = (state_r == ST_ADDR) && scl_fall && (cnt_r == BYTE_BITS)
                      && (shift_r[7:1] == own_addr_r[7:1]);  // RULE16
    assign ev_byte  = scl_fall && ((state_r == ST_TXACK) || (state_r == ST_RXACK));

    always_ff @(posedge clk) begin
        if (!rstn || tmo_ovf || !enabled) begin
            state_r <= ST_IDLE;  // RULE13
            cnt_r <= 4'h0;
            shift_r <= RST_BYTE;
            tx_sh_r <= RST_BYTE;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            match_r <= 1'b0;
            busy_r <= 1'b0;
            mrreq_r <= 1'b0;
            ackrcv_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            busy_r <= 1'b0;
            match_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            busy_r <= 1'b1;
            match_r <= 1'b0;
        end else begin
            if (scl_rise) begin
                shift_r <= {shift_r[6:0], lvl_r[SDA_IDX]};  // RULE4
                cnt_r <= cnt_r + 4'h1;
            end
            case (state_r)
                ST_ADDR: begin
                    if (scl_fall && (cnt_r == BYTE_BITS)) begin
                        cnt_r <= 4'h0;
                        if (ev_match) begin
                            sda_oe_r <= 1'b1;  // RULE1
                            match_r <= 1'b1;  // RULE16
                            mrreq_r <= shift_r[0];  // RULE17
                            state_r <= ST_AACK;
                        end else begin
                            state_r <= ST_WAIT;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        sda_oe_r <= 1'b0;
                        scl_oe_r <= 1'b1;  // RULE8
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_r <= 4'h0;
                    if (release_hold) begin
                        scl_oe_r <= 1'b0;  // RULE8
                        if (txsel_r) begin
                            tx_sh_r <= reg_wdata;
                            sda_oe_r <= !reg_wdata[7];  // RULE4
                            state_r <= ST_TX;
                        end else begin
                            state_r <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == BYTE_BITS) begin
                            sda_oe_r <= 1'b0;
                            cnt_r <= 4'h0;
                            state_r <= ST_TXACK;
                        end else begin
                            sda_oe_r <= !tx_sh_r[6];  // RULE4
                            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise)
                        ackrcv_r <= lvl_r[SDA_IDX];
                    if (scl_fall) begin
                        if (!ackrcv_r) begin
                            scl_oe_r <= 1'b1;  // RULE19
                            state_r <= ST_HOLD;
                        end else begin
                            state_r <= ST_WAIT;  // RULE6
                        end
                    end
                end
                ST_RX: begin
                    if (rx_load) begin
                        sda_oe_r <= !acksend_r;  // RULE5
                        cnt_r <= 4'h0;
                        state_r <= ST_RXACK;
                    end
                end
                ST_RXACK: begin
                    if (scl_fall) begin
                        sda_oe_r <= 1'b0;
                        scl_oe_r <= 1'b1;  // RULE19
                        state_r <= ST_HOLD;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_r <= 1'b0;  // RULE2 RULE6
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    assign events = {tmo_ovf, ev_byte, ev_match};  // RULE12 RULE16

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_r <= RST_IRQ;
            irq_en_r <= RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == REG_IRQ_CLR))
                irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | events;
            else
                irq_stat_r <= irq_stat_r | events;
            if (reg_wr && (reg_addr == REG_IRQ_EN))
                irq_en_r <= reg_wdata[2:0];
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    // ****************************************
    // read data and pin drive values
    // ****************************************
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            REG_CTRL_ZERO: rdata_nxt = ctrl_zero_r;
            REG_CTRL_ONE:  rdata_nxt = {match_r, busy_r, 1'b0, txsel_r, acksend_r, mrreq_r, 1'b0, ackrcv_r};
            REG_OWN_ADDR:  rdata_nxt = own_addr_r;
            REG_DATA:      rdata_nxt = data_r;
            REG_TMO_CTRL:  rdata_nxt = tmo_ctrl_r;
            REG_IRQ_STAT:  rdata_nxt = {5'h00, irq_stat_r};
            REG_IRQ_EN:    rdata_nxt = {5'h00, irq_en_r};
            default:       rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata_r <= 8'h00;
            scl_o_r <= 1'b0;
            sda_o_r <= 1'b0;
        end else begin
            reg_rdata_r <= reg_rd ? rdata_nxt : 8'h00;
            scl_o_r <= 1'b0;
            sda_o_r <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_addr_ack_drive: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        (ev_match && !tmo_ovf) |=> sda_oe_r && match_r && (state_r == ST_AACK))
        else $error("no acknowledge after address match");

    a_txsel_written: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        (reg_wr && reg_addr == REG_CTRL_ONE && !tmo_ovf) |=> txsel_r == $past(reg_wdata[C1_TXSEL]))
        else $error("transmit select not taken from write");

    a_msb_first: assert property (@(posedge clk) disable iff (!rstn) // RULE4
        (release_hold && txsel_r && !stop_det && !start_det && !tmo_ovf && enabled)
        |=> sda_oe_r == !$past(reg_wdata[7]))
        else $error("first bit sent is not msb");

    a_rx_ack_level: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        (rx_load && !stop_det && !start_det && !tmo_ovf && enabled) |=> sda_oe_r == !$past(acksend_r))
        else $error("receiver acknowledge level wrong");

    a_nack_release: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        (state_r == ST_TXACK && scl_fall && ackrcv_r) |=> !sda_oe_r ##1 !sda_oe_r)
        else $error("data line not released after no acknowledge");

    a_rx_buffer: assert property (@(posedge clk) disable iff (!rstn) // RULE7
        rx_load |=> data_r == $past(shift_r))
        else $error("received byte not stored in buffer");

    a_hold_clock: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        (state_r == ST_HOLD && !release_hold && !stop_det && !start_det && !tmo_ovf && enabled)
        |=> scl_oe_r)
        else $error("clock line not held in hold state");

    a_tmo_effect: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        tmo_ovf |=> !tmo_ctrl_r[TO_ENABLE] && tmo_ctrl_r[TO_FLAG] && irq_stat_r[IRQ_TMO])
        else $error("time-out effects missing");

    a_tmo_reset: assert property (@(posedge clk) disable iff (!rstn) // RULE13
        tmo_ovf |=> (state_r == ST_IDLE) && !txsel_r && !match_r && !scl_oe_r && $stable(own_addr_r))
        else $error("time-out did not reset interface");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn) // RULE14
        (tmo_ctrl_r[TO_FLAG] && !(reg_wr && reg_addr == REG_TMO_CTRL && !reg_wdata[TO_FLAG]))
        |=> tmo_ctrl_r[TO_FLAG])
        else $error("time-out flag cleared without software zero");

    c_match: cover property (@(posedge clk) disable iff (!rstn) ev_match);
    c_tx_byte: cover property (@(posedge clk) disable iff (!rstn) state_r == ST_TXACK && scl_fall);
    c_rx_byte: cover property (@(posedge clk) disable iff (!rstn) rx_load);
    c_timeout: cover property (@(posedge clk) disable iff (!rstn) tmo_ovf);

endmodule // i2cs_slave

// File: bench/i2cs_master_bfm.sv
/*
 * behavioural two-wire bus master that drives the slave from the bench.
 * assumes open-drain wires resolved by the bench with pull-ups.
 */
`timescale 1ns/100ps
module i2cs_master_bfm (
    // clock
    input  wire logic clk,
    // resolved wires
    input  wire logic scl,
    input  wire logic sda,
    // pull-down requests
    output logic      scl_low,
    output logic      sda_low
);
    int hung = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic half();
        repeat (16) @(posedge clk);
    endtask
    // release the clock and wait out a stretch
    task automatic rise();
        int n = 0;
        scl_low <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (scl !== 1'b1 && n < 3000);
        if (n >= 3000) hung++;
        half();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        half();
        rise();
        r = sda;
        scl_low <= 1'b1;
        half();
    endtask
    task automatic start();
        sda_low <= 1'b0;
        half();
        rise();
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b1;
        half();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        half();
        rise();
        sda_low <= 1'b0;
        half();
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a, ak);
    endtask
endmodule // i2cs_master_bfm

// File: bench/tb_i2c_slave_data_ack_timeout.sv
/*
 * self-checking bench of the two-wire slave: registers, transfers, time-out.
 * assumes the package and the master model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_i2c_slave_data_ack_timeout;
    import i2cs_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [2:0] sub_cnt = 3'h0;
    logic [7:0] reg_rdata_r, q, v;
    logic       scl_o_r, scl_oe_r, sda_o_r, sda_oe_r, irq_r, ak, m_scl_low, m_sda_low;
    int         n_mismatch = 0;
    int         total_checks = 0;
    wire logic  scl = !m_scl_low && (scl_oe_r ? scl_o_r : 1'b1);
    wire logic  sda = !m_sda_low && (sda_oe_r ? sda_o_r : 1'b1);
    localparam logic [19:0] ROWS [10] = '{{REG_TMO_CTRL, 8'hff, 8'hbf}, {REG_TMO_CTRL, 8'h00, 8'h00},
        {REG_CTRL_ONE, 8'hff, 8'h18}, {REG_CTRL_ONE, 8'h00, 8'h00}, {REG_OWN_ADDR, 8'ha5, 8'ha4},
        {REG_IRQ_CLR, 8'hff, 8'h00}, {REG_IRQ_EN, 8'hff, 8'h07}, {4'h9, 8'hff, 8'h00},
        {REG_DATA, 8'h5a, 8'h5a}, {REG_CTRL_ZERO, 8'h01, 8'h01}};
    always #4 clk = ~clk;
    always @(posedge clk) sub_cnt <= sub_cnt + 3'h1;
    i2cs_slave i_i2cs_slave (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .scl_i(scl), .scl_o_r(scl_o_r),
        .scl_oe_r(scl_oe_r), .sda_i(sda), .sda_o_r(sda_o_r), .sda_oe_r(sda_oe_r),
        .subclk_i(sub_cnt[2]), .irq_r(irq_r));
    i2cs_master_bfm i_i2cs_master_bfm (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
        .sda_low(m_sda_low));
    task automatic results();
        n_mismatch += i_i2cs_master_bfm.hung;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) #1;
        reg_wr <= 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) #1;
        d = reg_rdata_r;
        reg_rd <= 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a, v);
        `CHK(v, e)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rstn <= 1'b1;
        @(posedge clk) #1;
        for (int i = 0; i < 8; i++) rdc(4'(i), 8'h00);
        `CHK({irq_r, scl_oe_r, sda_oe_r}, 3'b000)
        foreach (ROWS[i]) begin
            wr(ROWS[i][19:16], ROWS[i][15:8]);
            rdc(ROWS[i][19:16], ROWS[i][7:0]);
        end
        // receive two bytes, ack then no ack, with the watchdog running
        wr(REG_TMO_CTRL, 8'h80);
        i_i2cs_master_bfm.start();
        i_i2cs_master_bfm.xfer(8'ha4, 1'b1, q, ak);
        `CHK({ak, irq_r, scl_oe_r}, 3'b011)
        rd(REG_CTRL_ONE, v);
        `CHK(v & 8'h85, 8'h80)
        rdc(REG_IRQ_STAT, 8'h01);
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_IRQ_CLR, 8'h07);
        `CHK(scl_oe_r, 1'b1)
        rd(REG_DATA, v);
        `CHK(scl_oe_r, 1'b0)
        for (int k = 0; k < 2; k++) begin
            i_i2cs_master_bfm.xfer(8'hc3 ^ 8'(k * 255), 1'b1, q, ak);
            `CHK({ak, scl_oe_r}, {1'(k), 1'b1})
            rdc(REG_IRQ_STAT, 8'h02);
            wr(REG_IRQ_CLR, 8'h07);
            wr(REG_CTRL_ONE, 8'h08);
            rdc(REG_DATA, 8'hc3 ^ 8'(k * 255));
        end
        i_i2cs_master_bfm.stop();
        repeat (400) @(posedge clk);
        rdc(REG_TMO_CTRL, 8'h80);
        // transmit two bytes, master acks then refuses
        i_i2cs_master_bfm.start();
        i_i2cs_master_bfm.xfer(8'ha5, 1'b1, q, ak);
        rd(REG_CTRL_ONE, v);
        `CHK({ak, v[C1_MRREQ]}, 2'b01)
        wr(REG_CTRL_ONE, 8'h10);
        for (int k = 0; k < 2; k++) begin
            wr(REG_DATA, 8'ha6 ^ 8'(k * 255));
            `CHK(scl_oe_r, 1'b0)
            i_i2cs_master_bfm.xfer(8'hff, 1'(k), q, ak);
            `CHK(q, 8'ha6 ^ 8'(k * 255))
            rd(REG_CTRL_ONE, v);
            `CHK({v[C1_ACKRCV], scl_oe_r, sda_oe_r}, {1'(k), 1'(1 - k), 1'b0})
        end
        i_i2cs_master_bfm.stop();
        // foreign address is ignored
        wr(REG_IRQ_CLR, 8'h07);
        i_i2cs_master_bfm.start();
        i_i2cs_master_bfm.xfer(8'h22, 1'b1, q, ak);
        `CHK({ak, scl_oe_r, irq_r}, 3'b100)
        i_i2cs_master_bfm.stop();
        // stalled clock line ends in a time-out
        i_i2cs_master_bfm.start();
        i_i2cs_master_bfm.xfer(8'ha4, 1'b1, q, ak);
        wr(REG_IRQ_CLR, 8'h07);
        repeat (180) @(posedge clk);
        rdc(REG_TMO_CTRL, 8'h80);
        for (int n = 0; irq_r !== 1'b1; n++) begin
            @(posedge clk) #1;
            if (n > 2000) begin
                n_mismatch++;
                results();
            end
        end
        rdc(REG_TMO_CTRL, 8'h40);
        rdc(REG_IRQ_STAT, 8'h04);
        rdc(REG_CTRL_ONE, 8'h00);
        rdc(REG_OWN_ADDR, 8'ha4);
        rdc(REG_DATA, 8'h59);
        `CHK(scl_oe_r, 1'b0)
        wr(REG_IRQ_EN, 8'h03);
        `CHK(irq_r, 1'b0)
        wr(REG_TMO_CTRL, 8'h40);
        rdc(REG_TMO_CTRL, 8'h40);
        wr(REG_TMO_CTRL, 8'h00);
        rdc(REG_TMO_CTRL, 8'h00);
        i_i2cs_master_bfm.stop();
        results();
    end
endmodule // tb_i2c_slave_data_ack_timeout
